// File: adc_output_formatter.sv
/*
 * Digital side of a 14-bit pipelined converter: sample clock timing,
 * five-stage result alignment, correction, coding, scrambling, overflow
 * and tristate output bus. Assumes the quantizer stage decisions arrive
 * as stage codes on the system clock, and the sample clock and static
 * control pins come from outside and are synchronised here.
 */
`timescale 1ns/1ns
module adc_output_formatter
    import adc_fmt_pkg::*;
#(
    parameter int STAGES  = adc_fmt_pkg::STAGE_COUNT,
    parameter int LATENCY = adc_fmt_pkg::LATENCY_CYC
) (
    // Clock and reset
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rst_n,
    // Sample clock, differential
    input  wire logic                          i_sample_clock_p,
    input  wire logic                          i_sample_clock_n,
    // Stage decisions, one code per stage
    input  wire logic [STAGES*3-1:0]           i_stage_code,
    // Static controls (pins)
    input  wire logic [1:0]                    i_mode_level,
    input  wire logic                          i_output_scramble_select,
    input  wire logic                          i_front_gain_select,
    input  wire logic                          i_output_enable_n,
    input  wire logic                          i_power_down_request,
    // Receiver handshake
    input  wire logic                          i_rx_ready,
    // Front-end and timing status
    output logic                               o_track,
    output logic [1:0]                         o_stage_phase_odd,
    output logic                               o_stabilizer_on,
    output logic                               o_gain_high,
    output logic                               o_convert_en,
    // Output bus, two signals per pin
    output logic [13:0]                        o_sample_word_out,
    output logic [13:0]                        o_sample_word_out_oe,
    output logic                               o_range_overflow_flag,
    output logic                               o_range_overflow_flag_oe,
    output logic                               o_data_valid_clock_out_p,
    output logic                               o_data_valid_clock_out_n,
    output logic                               o_data_valid_clock_out_oe,
    output logic                               o_word_valid,
    output logic                               o_fill_ready
);
    import adc_fmt_pkg::*;

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    logic [6:0] meta_q;
    logic [6:0] sync_q;
    logic       enc_q;
    logic       enc_rise;
    logic       enc_fall;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            meta_q <= 7'h00;
            sync_q <= 7'h00;
        end else begin
            // Both clock legs synced apart; no gate ahead of the flops
            meta_q <= {i_sample_clock_p, i_sample_clock_n,
                       i_mode_level, i_output_scramble_select,
                       i_front_gain_select, i_power_down_request};
            sync_q <= meta_q;
        end
    end

    logic      enc_lvl;
    logic      scramble_en;
    logic      gain_high;
    logic      pwr_down;
    out_mode_t mode;

    // A skewed pair may show both legs equal for a cycle; reads as low
    assign enc_lvl     = sync_q[6] && !sync_q[5];
    assign mode        = out_mode_t'(sync_q[4:3]);
    assign scramble_en = sync_q[2];
    assign gain_high   = sync_q[1];
    assign pwr_down    = sync_q[0];

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            enc_q <= 1'b0;
        end else begin
            enc_q <= enc_lvl;
        end
    end

    assign enc_rise = enc_lvl && !enc_q;
    assign enc_fall = !enc_lvl && enc_q;

    // -----------------------------------------------------------------
    // Mode decode
    // -----------------------------------------------------------------
    function automatic mode_cfg_t decode_mode(input out_mode_t m);
        mode_cfg_t c;
        c = '0;
        case (m)
            MODE_OB_DCS_OFF: c = '{twos_comp: 1'b0, stabilizer_on: 1'b0};
            MODE_OB_DCS_ON:  c = '{twos_comp: 1'b0, stabilizer_on: 1'b1};
            MODE_TC_DCS_ON:  c = '{twos_comp: 1'b1, stabilizer_on: 1'b1};
            default:         c = '{twos_comp: 1'b1, stabilizer_on: 1'b0};
        endcase
        return c;
    endfunction : decode_mode

    mode_cfg_t cfg;
    assign cfg = decode_mode(mode);

    // -----------------------------------------------------------------
    // Front-end status
    // -----------------------------------------------------------------
    assign o_stabilizer_on = cfg.stabilizer_on;
    assign o_gain_high     = gain_high;
    assign o_convert_en    = !pwr_down;
    assign o_track         = !enc_lvl && !pwr_down;

    // -----------------------------------------------------------------
    // Stage phase: odd stages outputting while even acquire
    // -----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_stage_phase_odd <= 2'b01;
        end else if (enc_rise || enc_fall) begin
            o_stage_phase_odd <= ~o_stage_phase_odd;
        end
    end

    // -----------------------------------------------------------------
    // Stage alignment: stage k result delayed by STAGES-1-k samples
    // -----------------------------------------------------------------
    // Only sample-clock rising edges advance the chain, so latency is
    // counted in samples, not system clocks.
    logic [2:0] align_q [STAGES][STAGES];

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int s = 0; s < STAGES; s++) begin
                for (int d = 0; d < STAGES; d++) begin
                    align_q[s][d] <= 3'h0;
                end
            end
        end else if (enc_rise && !pwr_down) begin
            for (int s = 0; s < STAGES; s++) begin
                align_q[s][0] <= i_stage_code[s*3 +: 3];
                for (int d = 1; d < STAGES; d++) begin
                    align_q[s][d] <= align_q[s][d-1];
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // Correction: overlapping 3-bit stage codes summed with 2-bit weight
    // -----------------------------------------------------------------
    function automatic logic [RAW_W-1:0] correct(
        input logic [STAGES*3-1:0] codes
    );
        logic [RAW_W-1:0] acc;
        acc = '0;
        for (int s = 0; s < STAGES; s++) begin
            acc = RAW_W'((acc << 2) + RAW_W'(codes[s*3 +: 3]));
        end
        acc = RAW_W'(acc << 4);
        return acc;
    endfunction : correct

    logic [STAGES*3-1:0] aligned;
    always_comb begin
        aligned = '0;
        for (int s = 0; s < STAGES; s++) begin
            // Stage s is STAGES-1-s samples ahead of the last stage
            aligned[s*3 +: 3] = align_q[s][STAGES-1-s];
        end
    end

    logic [RAW_W-1:0] raw;
    logic [13:0]      clipped;
    logic             ovf;
    assign raw = correct(aligned);
    assign ovf = raw[RAW_W-1];
    // Saturate out-of-range codes to the rail on the side they left by;
    // once bit 14 is set, raw bit 13 tells above from below
    always_comb begin
        clipped = raw[13:0];
        if (ovf) begin
            clipped = {14{raw[RAW_W-2]}};
        end
    end

    // -----------------------------------------------------------------
    // Coding and scrambling
    // -----------------------------------------------------------------
    logic [13:0] coded;
    logic [13:0] scrambled;
    always_comb begin
        coded = clipped;
        if (cfg.twos_comp) begin
            coded[13] = ~clipped[13];
        end
        scrambled = coded;
        if (scramble_en) begin
            // Receiver inverts by the same XOR with bit 0
            scrambled[13:1] = coded[13:1] ^ {13{coded[0]}};
        end
    end

    // -----------------------------------------------------------------
    // Latency pipeline, flag carried with the word
    // -----------------------------------------------------------------
    // Alignment chain plus correction account for STAGES-1 samples.
    localparam int TAIL = LATENCY - (STAGES - 1);
    sample_t tail_q [TAIL];

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int t = 0; t < TAIL; t++) begin
                tail_q[t] <= '{word: WORD_RST, range_overflow_flag: 1'b0};
            end
        end else if (enc_rise && !pwr_down) begin
            tail_q[0] <= '{word: scrambled, range_overflow_flag: ovf};
            for (int t = 1; t < TAIL; t++) begin
                tail_q[t] <= tail_q[t-1];
            end
        end
    end

    // -----------------------------------------------------------------
    // Two-entry buffer toward the receiver
    // -----------------------------------------------------------------
    logic    buf_valid;
    sample_t buf_data;
    logic    fill_pulse;
    logic    fill_q;

    // Fill one cycle after the rise, once tail_q holds the new word;
    // a full buffer refuses the fill and that word is dropped
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            fill_q <= 1'b0;
        end else begin
            fill_q <= enc_rise && !pwr_down;
        end
    end
    assign fill_pulse = fill_q;

    sample_skid_buf #(
        .W (RAW_W)
    ) u_buf (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (fill_pulse),
        .o_in_ready  (o_fill_ready),
        .i_in_data   (tail_q[TAIL-1]),
        .o_out_valid (buf_valid),
        .i_out_ready (i_rx_ready),
        .o_out_data  (buf_data)
    );

    // -----------------------------------------------------------------
    // Output registers and data-valid clock
    // -----------------------------------------------------------------
    sample_t out_q;
    logic    dv_q;
    logic    oe_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            out_q <= '{word: WORD_RST, range_overflow_flag: 1'b0};
            dv_q  <= 1'b0;
        end else begin
            if (buf_valid && i_rx_ready) begin
                out_q <= buf_data;
                dv_q  <= ~dv_q;
            end
        end
    end

    // Enable pin reads as disabled in reset, so pins float until it is
    // seen low; power-down gates the same flop
    logic oe_pin_meta_q;
    logic oe_pin_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            oe_pin_meta_q <= 1'b1;
            oe_pin_q      <= 1'b1;
            oe_q          <= 1'b0;
        end else begin
            oe_pin_meta_q <= i_output_enable_n;
            oe_pin_q      <= oe_pin_meta_q;
            oe_q          <= !oe_pin_q && !pwr_down;
        end
    end

    assign o_word_valid              = buf_valid;
    assign o_sample_word_out         = out_q.word;
    assign o_range_overflow_flag     = out_q.range_overflow_flag;
    assign o_sample_word_out_oe      = {14{oe_q}};
    assign o_range_overflow_flag_oe  = oe_q;
    assign o_data_valid_clock_out_p  = ~dv_q;
    assign o_data_valid_clock_out_n  = dv_q;
    assign o_data_valid_clock_out_oe = oe_q;
endmodule : adc_output_formatter

// File: adc_fmt_pkg.sv
/*
 * Shared constants and carrier types for the pipelined converter output
 * formatter. Assumes a single 100 MHz system clock domain.
 */
// What this block does
// - Overflow flag high when sample exceeds full scale either way, else low.
// - Output enable low drives outputs; high puts them in high impedance.
// - Mode level picks coding and stabilizer: OB/off, OB/on, 2C/on, 2C/off.
// - Scramble select high XORs bits 1..13 with bit 0; low leaves bits.
// - Gain select low gives gain 1, 2.25 V; high gives 1.5, 1.5 V.
// - Result of a sample appears on the bus seven sample clocks later.
// - Five pipelined stages; neighbouring stages use opposite clock phases.
// - Track while sample clock low; hold at its rising edge.
// - Stage results delayed to align, then merged in correction logic.
// - Output bus is 14 bits, bit 13 most significant.
// - Power-down high stops conversion and floats all digital outputs.
// - Data-valid clock toggles at sample rate; capture on its edge.
package adc_fmt_pkg;

    // -----------------------------------------------------------------
    // Sizes and counts
    // -----------------------------------------------------------------
    localparam int          WORD_W        = 14;
    localparam int          STAGE_COUNT   = 5;
    localparam int          LATENCY_CYC   = 7;
    localparam int          STAGE_BITS    = 3;
    localparam int          RAW_W         = 15;

    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [13:0] WORD_RST      = 14'h0000;
    localparam logic [1:0]  MODE_RST      = 2'h0;

    // -----------------------------------------------------------------
    // Mode levels and derived settings
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_OB_DCS_OFF = 2'b00,
        MODE_OB_DCS_ON  = 2'b01,
        MODE_TC_DCS_ON  = 2'b10,
        MODE_TC_DCS_OFF = 2'b11
    } out_mode_t;

    typedef struct packed {
        logic        twos_comp;
        logic        stabilizer_on;
    } mode_cfg_t;

    typedef struct packed {
        logic [13:0] word;
        logic        range_overflow_flag;
    } sample_t;

endpackage : adc_fmt_pkg

// File: sample_skid_buf.sv
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes both sides on the system clock.
 */
`timescale 1ns/1ns
module sample_skid_buf #(
    parameter int W = 15
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst_n,
    // Fill side
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    // Drain side
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);
    logic [W-1:0] mem_q [2];
    logic         rd_q;
    logic         wr_q;
    logic [1:0]   cnt_q;
    logic         push;
    logic         pop;

    assign o_in_ready  = (cnt_q != 2'd2);
    assign o_out_valid = (cnt_q != 2'd0);
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : sample_skid_buf

// File: fmt_checker.sv
/* Concurrent checks on the converter output formatter ports.
   Assumes a bind to the formatter top, one clock, sync active-low reset. */
`timescale 1ns/1ns
module fmt_checker (
    // Clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    // Watched inputs
    input wire logic        i_sample_clock_p,
    input wire logic        i_sample_clock_n,
    input wire logic [1:0]  i_mode_level,
    input wire logic        i_front_gain_select,
    input wire logic        i_output_enable_n,
    input wire logic        i_power_down_request,
    input wire logic        i_rx_ready,
    // Watched outputs
    input wire logic        o_track,
    input wire logic [1:0]  o_stage_phase_odd,
    input wire logic        o_stabilizer_on,
    input wire logic        o_gain_high,
    input wire logic        o_convert_en,
    input wire logic [13:0] o_sample_word_out,
    input wire logic [13:0] o_sample_word_out_oe,
    input wire logic        o_range_overflow_flag_oe,
    input wire logic        o_data_valid_clock_out_p,
    input wire logic        o_data_valid_clock_out_n,
    input wire logic        o_data_valid_clock_out_oe,
    input wire logic        o_word_valid
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    // ------------------------------------------------------------
    // Sequences and assertions
    // ------------------------------------------------------------
    // Pins pass a synchroniser, so each wants a few steady cycles
    sequence awake_s;
        (!i_power_down_request)[*6];
    endsequence
    sequence enc_rise_s;
        awake_s ##0 $rose(i_sample_clock_p);
    endsequence
    oe_off_a: assert property (i_output_enable_n[*4] |->
        o_sample_word_out_oe == 14'h0000 && !o_range_overflow_flag_oe)
        else $error("output pins driven while disabled");
    oe_on_a: assert property ((!i_output_enable_n)[*4] and awake_s
        |-> o_sample_word_out_oe == 14'h3FFF && o_data_valid_clock_out_oe)
        else $error("output pins not driven while enabled");
    pd_float_a: assert property (i_power_down_request[*4] |->
        !o_convert_en && !o_track && o_sample_word_out_oe == 14'h0000
        && !o_data_valid_clock_out_oe) else $error("power-down ignored");
    stab_mode_a: assert property (($stable(i_mode_level))[*4] |->
        o_stabilizer_on == (i_mode_level == 2'h1 || i_mode_level == 2'h2))
        else $error("stabilizer does not follow mode");
    gain_sel_a: assert property (($stable(i_front_gain_select))[*4]
        |-> o_gain_high == i_front_gain_select) else $error("gain wrong");
    dv_pair_a: assert property (
        o_data_valid_clock_out_p != o_data_valid_clock_out_n)
        else $error("data valid pair not complementary");
    phase_hot_a: assert property (
        o_stage_phase_odd == 2'h1 || o_stage_phase_odd == 2'h2)
        else $error("stage phases not opposite");
    phase_step_a: assert property (enc_rise_s |->
        ##[1:6] $changed(o_stage_phase_odd)) else $error("phase stuck");
    track_low_a: assert property ((i_sample_clock_n &&
        !i_sample_clock_p && !i_power_down_request)[*5] |-> o_track)
        else $error("not tracking while sample clock low");
    stall_hold_a: assert property (!i_rx_ready |=>
        $stable(o_data_valid_clock_out_n) && $stable(o_sample_word_out))
        else $error("word moved while receiver stalled");
    buf_keep_a: assert property (o_word_valid && !i_rx_ready |=> o_word_valid)
        else $error("buffered word lost during stall");
endmodule : fmt_checker

// File: rx_model.sv
/* Receiver model latching parallel sample words.
   Assumes the word lines already show the resolved pin level. */
`timescale 1ns/1ns
module rx_model (
    // Clock
    input  wire logic        i_clk_sys,
    // Control
    input  wire logic        i_stall,
    input  wire logic        i_descramble,
    // Pins
    input  wire logic        i_dv_n,
    input  wire logic [13:0] i_word,
    // Results
    output logic             o_rx_ready,
    output logic [13:0]      o_word_q,
    output logic [15:0]      o_count_q
);
    logic dv_q;
    assign o_rx_ready = !i_stall;
    initial begin
        dv_q = 1'b0;
        o_word_q = 14'h0000;
        o_count_q = 16'h0000;
    end
    // Word stands until next toggle, so either edge is safe
    always @(posedge i_clk_sys) begin
        dv_q <= i_dv_n;
        if (i_dv_n != dv_q) begin
            o_count_q <= o_count_q + 16'h0001;
            o_word_q <= i_descramble ?
                i_word ^ {{13{i_word[0]}}, 1'b0} : i_word;
        end
    end
endmodule : rx_model

// File: testbench.sv
/* Self-checking bench for the converter output formatter.
   Assumes default parameters and the receiver model beside it. */
`timescale 1ns/1ns
module testbench;
    import adc_fmt_pkg::*;
    logic        i_clk_sys, i_rst_n, i_sample_clock_p, i_sample_clock_n;
    logic [14:0] i_stage_code;
    logic [1:0]  i_mode_level, o_stage_phase_odd;
    logic        i_output_scramble_select, i_front_gain_select;
    logic        i_output_enable_n, i_power_down_request, i_rx_ready;
    logic        o_track, o_stabilizer_on, o_gain_high, o_convert_en;
    logic [13:0] o_sample_word_out, o_sample_word_out_oe, bus, rx_word;
    logic        o_range_overflow_flag, o_range_overflow_flag_oe;
    logic        o_data_valid_clock_out_p, o_data_valid_clock_out_n;
    logic        o_data_valid_clock_out_oe, o_word_valid, o_fill_ready;
    logic        stall;
    logic [2:0]  code;
    logic [15:0] rx_count, n0;
    logic [14:0] e;
    int          failures, samples_checked;
    logic [2:0]  codes [4] = '{3'h0, 3'h3, 3'h4, 3'h6};
    // ------------------------------------------------------------
    // Wiring
    // ------------------------------------------------------------
    assign i_stage_code = {5{code}};
    // Released pins show a pattern that flips every half cycle
    assign bus = (o_sample_word_out & o_sample_word_out_oe) |
        (~o_sample_word_out_oe & ({7{2'b10}} ^ {14{i_clk_sys}}));
    adc_output_formatter i_dut (.*);
    rx_model i_rx (.i_clk_sys(i_clk_sys), .i_stall(stall),
        .i_descramble(i_output_scramble_select),
        .i_dv_n(o_data_valid_clock_out_n), .i_word(bus),
        .o_rx_ready(i_rx_ready), .o_word_q(rx_word), .o_count_q(rx_count));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Equal codes make the result independent of stage order
    function automatic logic [14:0] expect_out(input logic [2:0] c,
            input logic [1:0] m, input logic s);
        logic [15:0] a;
        logic [14:0] r;
        logic [13:0] w;
        a = {13'h0000, c} * 16'h0155;
        r = {a[10:0], 4'h0};
        w = r[14] ? {14{r[13]}} : r[13:0];
        if (m[1]) w[13] = ~w[13];
        if (s) w[13:1] = w[13:1] ^ {13{w[0]}};
        return {r[14], w};
    endfunction : expect_out
    task automatic check_word(input logic [13:0] got, input logic [13:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_word
    task automatic check_bit(input logic got, input logic exp);
        check_word({13'h0000, got}, {13'h0000, exp});
    endtask : check_bit
    task automatic periods(input int n);
        repeat (n) begin
            i_sample_clock_p = 1'b1;
            i_sample_clock_n = 1'b0;
            repeat (6) @(negedge i_clk_sys);
            check_bit(o_track, 1'b0);
            repeat (2) @(negedge i_clk_sys);
            i_sample_clock_p = 1'b0;
            i_sample_clock_n = 1'b1;
            repeat (6) @(negedge i_clk_sys);
            check_bit(o_track, !i_power_down_request);
            repeat (2) @(negedge i_clk_sys);
        end
    endtask : periods
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {i_rst_n, i_sample_clock_p, i_mode_level, stall, code} = '0;
        {i_output_scramble_select, i_front_gain_select} = 2'h0;
        {i_output_enable_n, i_power_down_request} = 2'h0;
        i_sample_clock_n = 1'b1;
        failures = 0;
        samples_checked = 0;
        repeat (8) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        for (int m = 0; m < 4; m++) for (int s = 0; s < 2; s++)
            foreach (codes[i]) begin
                i_mode_level = 2'(m);
                i_output_scramble_select = 1'(s);
                i_front_gain_select = 1'(s);
                code = codes[i];
                periods(9);
                e = expect_out(code, i_mode_level, 1'(s));
                check_word(bus, e[13:0]);
                check_bit(o_range_overflow_flag, e[14]);
                e = expect_out(code, i_mode_level, 1'b0);
                check_word(rx_word, e[13:0]);
                check_bit(o_stabilizer_on, m == 1 || m == 2);
                check_bit(o_gain_high, 1'(s));
            end
        $display("test format done");
        {i_mode_level, i_output_scramble_select, code} = {3'h0, 3'h1};
        periods(9);
        code = 3'h6;
        periods(7);
        // Sample of the last old rise: stage 0 old code, stages 1-4 new
        check_word(bus, 14'h2FE0);
        check_bit(o_range_overflow_flag, 1'b0);
        periods(1);
        check_word(bus, 14'h3FFF);
        check_bit(o_range_overflow_flag, 1'b1);
        $display("test latency done");
        stall = 1'b1;
        n0 = rx_count;
        code = 3'h3;
        periods(4);
        check_bit(o_fill_ready, 1'b0);
        check_bit(o_word_valid, 1'b1);
        check_word(14'(rx_count - n0), 14'h0000);
        stall = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        check_word(14'(rx_count - n0), 14'h0002);
        check_bit(o_word_valid, 1'b0);
        $display("test stall done");
        i_output_enable_n = 1'b1;
        repeat (5) @(negedge i_clk_sys);
        check_word(o_sample_word_out_oe, 14'h0000);
        check_bit(o_data_valid_clock_out_oe, 1'b0);
        i_output_enable_n = 1'b0;
        repeat (5) @(negedge i_clk_sys);
        check_word(o_sample_word_out_oe, 14'h3FFF);
        i_power_down_request = 1'b1;
        n0 = rx_count;
        code = 3'h0;
        periods(10);
        check_bit(o_convert_en, 1'b0);
        check_word(o_sample_word_out_oe, 14'h0000);
        check_word(14'(rx_count - n0), 14'h0000);
        i_power_down_request = 1'b0;
        periods(9);
        check_word(bus, 14'h0000);
        $display("test pins done");
        give_verdict();
    end
    // Tests need about 5300 cycles; allow well over three times that
    initial begin
        #200000;
        failures++;
        give_verdict();
    end
endmodule : testbench
bind adc_output_formatter fmt_checker i_chk (.*);
